// file: rtl/kmsp_port.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Device always makes the link clock; host may only pull it low.
// - Frame is start bit, eight data bits, odd parity, stop bit.
// - Parity makes data plus parity hold an odd count of ones.
// - Host drives data inbound; device pulls data low after stop to acknowledge.
// - Device drives data outbound; host pulling data low is a request to send.
// - Link clock period is 80 us, divided from the CPU clock.
// - Device waits 100 us after clock release before first falling edge inbound.
// - Inbound: three samples 2.5 us apart, first 12.5 to 17.5 us after edge.
// - Outbound: three samples 2.5 us apart, first 12.5 to 17.5 us after edge.
// - Frequency and timing settings change only while the port is off.
// - With timing on: 100 us frame gap, inhibit gap and request response delay.
// - Switched on, port goes from off to idle; returns to idle after each frame or inhibit abort.
// - Receive mode only becomes available after a host request to send.
// - Data write in transmit direction starts frame after gap, sets active bit.
// - Transmit end clears active bit, sets completion flag, interrupt if enabled.
// - Transmit aborts on software clear, inhibit or host request; flags set.
// - No transmit errors; clock fault is inhibit, data fault is request.
// - After host request, enter receive idle after delay or at once.
// - Receive end clears active, sets completion, interrupts, acknowledges host.
// - Only host inhibit aborts a reception; abort flag and interrupt follow.
// - After request abort, software enables request interrupt and restarts receive.
// - Parity error sets error flag, ends reception, still acknowledges host.
// - Frequency field selects divider: 12, 8, 6 or 4 MHz.
// - Error, request, abort and completion flags clear by writing one.
module kmsp_port
  import kmsp_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // APB slave
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Link lines, open drain
  input  wire kmsp_link_in_t      link_in,
  output kmsp_link_out_t          link_out,
  // Combined event request
  output logic                    irq
);

  typedef struct packed {
    kmsp_state_t    st;
    logic           eie;
    logic           hie;
    logic           aie;
    logic           cie;
    logic           act;
    logic           dir;
    logic           on;
    logic [1:0]     freq_select_field;
    logic           timing_disable_bit;
    logic           err;
    logic           hrq;
    logic           abt;
    logic           cmp;
    logic [7:0]     data;
    logic           pend;
    logic [5:0]     div;
    logic [5:0]     gap;
    logic [4:0]     tcnt;
    logic [3:0]     bitn;
    logic [10:0]    sh;
    logic [2:0]     smcl;
    logic [2:0]     smdl;
    kmsp_link_out_t lnk;
    logic           irq;
    logic           pready;
    logic           pslverr;
    logic [31:0]    prdata;
  } kmsp_regs_t;

  kmsp_regs_t s_r;
  kmsp_regs_t s_nxt;

  // Majority of three samples, so one disturbed sample is outvoted
  function automatic logic maj3(input logic [2:0] v);
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    return a == ADDR_W'({idx, 2'b00});
  endfunction

  always_comb
  begin
    logic       tick;
    logic       clk_hi;
    logic       dat_hi;
    logic       acc;
    logic       wr;
    logic       sw_abort;
    logic       set_cmp;
    logic       set_abt;
    logic       set_hrq;
    logic       set_err;
    logic       abort;
    logic       abort_rq;
    logic [7:0] clr;
    logic [7:0] rd;
    s_nxt    = s_r;
    tick     = 1'b0;
    clk_hi   = ~maj3(s_r.smcl);
    dat_hi   = ~maj3(s_r.smdl);
    acc      = psel & penable;
    wr       = acc & pwrite & s_r.pready;
    sw_abort = 1'b0;
    set_cmp  = 1'b0;
    set_abt  = 1'b0;
    set_hrq  = 1'b0;
    set_err  = 1'b0;
    abort    = 1'b0;
    abort_rq = 1'b0;
    clr      = 8'h00;
    rd       = 8'h00;

    // Tick divider; ratio picked by the frequency field
    if (!s_r.on || s_r.div == tick_div(s_r.freq_select_field) - 6'd1)
    begin
      s_nxt.div = 6'd0;
      tick      = s_r.on;
    end
    else
    begin
      s_nxt.div = s_r.div + 6'd1;
    end

    // Line samples every 2.5 us, kept inverted so reset means idle high
    if (tick)
    begin
      s_nxt.smcl = {s_r.smcl[1:0], ~link_in.clk};
      s_nxt.smdl = {s_r.smdl[1:0], ~link_in.dat};
    end

    // APB: one wait state, write lands on the pready edge
    s_nxt.pready  = acc & ~s_r.pready;
    s_nxt.pslverr = 1'b0;
    if (acc & ~s_r.pready)
    begin
      if (hit(paddr, CTRL_IDX))
        rd = {1'b0, s_r.eie, s_r.hie, s_r.aie, s_r.cie, s_r.act, s_r.dir, s_r.on};
      else if (hit(paddr, CSR_IDX))
        rd = {1'b0, s_r.freq_select_field, s_r.timing_disable_bit, s_r.err, s_r.hrq, s_r.abt, s_r.cmp};
      else if (hit(paddr, DATA_IDX))
        rd = s_r.act ? 8'h00 : s_r.data; // Hidden while a frame is live
      else
        s_nxt.pslverr = 1'b1;
      s_nxt.prdata = pwrite ? 32'h0000_0000 : {24'h00_0000, rd};
    end

    // Register writes
    if (wr && hit(paddr, CTRL_IDX))
    begin
      s_nxt.eie = pwdata[C_EIE];
      s_nxt.hie = pwdata[C_HIE];
      s_nxt.aie = pwdata[C_AIE];
      s_nxt.cie = pwdata[C_CIE];
      s_nxt.on  = pwdata[C_ON];
      if (!s_r.act)
        s_nxt.dir = pwdata[C_DIR];
      // Receive start only once a host request put us in receive idle
      if (pwdata[C_ACT] && s_r.st == ST_RXI && s_r.dir)
        s_nxt.act = 1'b1;
      // Clearing the active bit aborts a transmission, never a reception
      if (!pwdata[C_ACT] && (s_r.st == ST_TX || s_r.pend))
        sw_abort = 1'b1;
    end
    if (wr && hit(paddr, CSR_IDX))
    begin
      clr = pwdata[7:0];
      if (!s_r.on)
      begin
        s_nxt.freq_select_field = pwdata[S_FREQ_SELECT_FIELD +: 2];
        s_nxt.timing_disable_bit = pwdata[S_TIMING_DISABLE_BIT];
      end
    end
    if (wr && hit(paddr, DATA_IDX) && !s_r.act && !s_r.pend && !s_r.dir && s_r.on)
    begin
      s_nxt.data = pwdata[7:0];
      s_nxt.pend = 1'b1;
    end

    // Bit clock: 16 ticks released, 16 ticks pulled low
    if (tick && (s_r.st == ST_TX || s_r.st == ST_RX || s_r.st == ST_ACK))
    begin
      s_nxt.tcnt = s_r.tcnt + 5'd1;
      if (s_r.tcnt == HALF_TK - 5'd1)
        s_nxt.lnk.clk_oe = 1'b1;
      else if (s_r.tcnt == 5'd31)
        s_nxt.lnk.clk_oe = 1'b0;
    end

    case (s_r.st)
      ST_OFF:
      begin
        if (s_r.on)
        begin
          s_nxt.st  = ST_IDLE;
          s_nxt.gap = 6'd0;
        end
      end
      ST_IDLE:
      begin
        // One timer covers the frame gap and the gap after an inhibit
        if (tick)
        begin
          if (!clk_hi)
            s_nxt.gap = 6'd0;
          else if (s_r.gap != GAP_TK)
            s_nxt.gap = s_r.gap + 6'd1;
        end
        if (tick && clk_hi && !dat_hi)
        begin
          set_hrq    = 1'b1;
          s_nxt.pend = 1'b0;
          s_nxt.st   = ST_RXW;
          s_nxt.gap  = 6'd0;
        end
        else if (sw_abort)
        begin
          s_nxt.pend = 1'b0;
          set_abt    = 1'b1;
        end
        else if (s_r.pend && clk_hi && (s_r.timing_disable_bit || s_r.gap == GAP_TK))
        begin
          s_nxt.pend       = 1'b0;
          s_nxt.act        = 1'b1;
          s_nxt.st         = ST_TX;
          s_nxt.sh         = {1'b1, ~^s_r.data, s_r.data, 1'b0};
          s_nxt.bitn       = 4'd0;
          s_nxt.tcnt       = 5'd0;
          s_nxt.lnk.dat_oe = 1'b1;
        end
      end
      ST_RXW:
      begin
        // Response delay before the port may receive
        if (s_r.timing_disable_bit || s_r.gap == GAP_TK)
        begin
          s_nxt.st  = ST_RXI;
          s_nxt.gap = 6'd0;
        end
        else if (tick)
        begin
          s_nxt.gap = s_r.gap + 6'd1;
        end
      end
      ST_RXI:
      begin
        // 100 us of released clock before the first falling edge
        if (tick)
        begin
          if (!clk_hi || !s_r.act)
            s_nxt.gap = 6'd0;
          else if (s_r.gap != GAP_TK)
            s_nxt.gap = s_r.gap + 6'd1;
        end
        if (s_r.act && s_r.gap == GAP_TK)
        begin
          s_nxt.st   = ST_RX;
          s_nxt.bitn = 4'd0;
          s_nxt.tcnt = 5'd0;
          s_nxt.sh   = 11'h000;
        end
      end
      ST_TX:
      begin
        // Line faults read as inhibit or request, never as errors
        if (sw_abort)
        begin
          abort = 1'b1;
        end
        else if (tick && s_r.tcnt == DEC_TK)
        begin
          if (!clk_hi)
            abort = 1'b1;
          else if (!dat_hi && !s_r.lnk.dat_oe)
          begin
            abort    = 1'b1;
            abort_rq = 1'b1;
          end
        end
        else if (tick && s_r.tcnt == 5'd31)
        begin
          if (s_r.bitn == STOP_BIT)
          begin
            s_nxt.act        = 1'b0;
            set_cmp          = 1'b1;
            s_nxt.lnk.dat_oe = 1'b0;
            s_nxt.st         = ST_IDLE;
            s_nxt.gap        = 6'd0;
          end
          else
          begin
            s_nxt.bitn       = s_r.bitn + 4'd1;
            s_nxt.sh         = {1'b1, s_r.sh[10:1]};
            s_nxt.lnk.dat_oe = ~s_r.sh[1];
          end
        end
      end
      ST_RX:
      begin
        if (tick && s_r.tcnt == DEC_TK)
        begin
          if (!clk_hi)
            abort = 1'b1;
          else
            s_nxt.sh[s_r.bitn] = dat_hi;
        end
        else if (tick && s_r.tcnt == 5'd31)
        begin
          if (s_r.bitn != STOP_BIT)
          begin
            s_nxt.bitn = s_r.bitn + 4'd1;
          end
          else if (!s_r.sh[10])
          begin
            set_err = 1'b1; // Missing stop: keep clocking until it shows
          end
          else
          begin
            // Acknowledge in the next clock pulse, error or not
            s_nxt.st         = ST_ACK;
            s_nxt.lnk.dat_oe = 1'b1;
            s_nxt.data       = s_r.sh[8:1];
            if (!(^s_r.sh[9:1]))
            begin
              set_err    = 1'b1;
              s_nxt.data = DATA_RST;
            end
          end
        end
      end
      ST_ACK:
      begin
        if (tick && s_r.tcnt == 5'd31)
        begin
          s_nxt.lnk.dat_oe = 1'b0;
          s_nxt.act        = 1'b0;
          set_cmp          = 1'b1;
          s_nxt.st         = ST_IDLE;
          s_nxt.gap        = 6'd0;
        end
      end
      default:
      begin
        s_nxt.st = ST_OFF;
      end
    endcase

    // Common abort path; data is lost and the register clears
    if (abort)
    begin
      s_nxt.act        = 1'b0;
      set_abt          = 1'b1;
      set_hrq          = abort_rq;
      s_nxt.data       = DATA_RST;
      s_nxt.lnk.dat_oe = 1'b0;
      s_nxt.lnk.clk_oe = 1'b0;
      s_nxt.gap        = 6'd0;
      s_nxt.st         = abort_rq ? ST_RXW : ST_IDLE;
      // Drop stale samples of our own drive, else idle sees a false request
      s_nxt.smcl       = 3'b000;
      s_nxt.smdl       = 3'b000;
    end

    // Port off releases the lines and drops any transfer
    if (!s_r.on)
    begin
      s_nxt.st   = ST_OFF;
      s_nxt.act  = 1'b0;
      s_nxt.pend = 1'b0;
      s_nxt.lnk  = '0;
    end

    // Sticky flags: hardware set beats a software clear
    s_nxt.cmp = (s_r.cmp & ~clr[S_CMP]) | set_cmp;
    s_nxt.abt = (s_r.abt & ~clr[S_ABT]) | set_abt;
    s_nxt.hrq = (s_r.hrq & ~clr[S_HRQ]) | set_hrq;
    s_nxt.err = (s_r.err & ~clr[S_ERR]) | set_err;
    s_nxt.irq = (s_nxt.cmp & s_nxt.cie) | (s_nxt.abt & s_nxt.aie) |
                (s_nxt.hrq & s_nxt.hie) | (s_nxt.err & s_nxt.eie);
  end

  // Single state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign prdata   = s_r.prdata;
  assign pready   = s_r.pready;
  assign pslverr  = s_r.pslverr;
  assign link_out = s_r.lnk;
  assign irq      = s_r.irq;

endmodule

// file: rtl/kmsp_pkg.sv
package kmsp_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] CTRL_IDX = 8'h4E;
  localparam logic [7:0] CSR_IDX  = 8'h4F;
  localparam logic [7:0] DATA_IDX = 8'h50;

  // Control register bit positions
  localparam int C_ON  = 0;
  localparam int C_DIR = 1;
  localparam int C_ACT = 2;
  localparam int C_CIE = 3;
  localparam int C_AIE = 4;
  localparam int C_HIE = 5;
  localparam int C_EIE = 6;

  // Config/status register bit positions
  localparam int S_CMP  = 0;
  localparam int S_ABT  = 1;
  localparam int S_HRQ  = 2;
  localparam int S_ERR  = 3;
  localparam int S_TIMING_DISABLE_BIT = 4;
  localparam int S_FREQ_SELECT_FIELD = 5;

  // Reset values of the three registers
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CSR_RST  = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  // Timing, in ns, and derived counts of 2.5 us ticks
  localparam int TICK_NS = 2500;
  localparam int HALF_NS = 40000;
  localparam int GAP_NS  = 100000;
  localparam int SMP_NS  = 15000;
  localparam logic [4:0] HALF_TK = 5'(HALF_NS / TICK_NS);
  localparam logic [5:0] GAP_TK  = 6'(GAP_NS / TICK_NS);
  localparam logic [4:0] DEC_TK  = 5'(SMP_NS / TICK_NS + 2);
  localparam logic [3:0] STOP_BIT = 4'h0A;

  // CPU frequency per select code, in kHz
  localparam int F0_KHZ = 12000;
  localparam int F1_KHZ = 8000;
  localparam int F2_KHZ = 6000;
  localparam int F3_KHZ = 4000;

  typedef enum logic [3:0] {
    ST_OFF  = 4'b0000,
    ST_IDLE = 4'b0001,
    ST_RXW  = 4'b0011,
    ST_RXI  = 4'b0010,
    ST_RX   = 4'b0110,
    ST_ACK  = 4'b0111,
    ST_TX   = 4'b0101
  } kmsp_state_t;

  typedef struct packed {
    logic clk;
    logic dat;
  } kmsp_link_in_t;

  typedef struct packed {
    logic clk_o;
    logic clk_oe;
    logic dat_o;
    logic dat_oe;
  } kmsp_link_out_t;

  // Clock cycles per 2.5 us tick for a select code
  function automatic logic [5:0] tick_div(input logic [1:0] freq_select_field);
    int khz;
    case (freq_select_field)
      2'b00:   khz = F0_KHZ;
      2'b01:   khz = F1_KHZ;
      2'b10:   khz = F2_KHZ;
      default: khz = F3_KHZ;
    endcase
    return 6'(khz * TICK_NS / 1000000);
  endfunction

endpackage

// file: bench/kmsp_port_properties.sv
`timescale 1ns/100ps
module kmsp_port_checker
  import kmsp_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // APB side
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Link and event
  input wire kmsp_link_in_t     link_in,
  input wire kmsp_link_out_t    link_out,
  input wire logic              irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Only the three register words answer without error
  logic mapped;
  assign mapped = paddr == ADDR_W'({CTRL_IDX, 2'b00}) || paddr == ADDR_W'({CSR_IDX, 2'b00})
                  || paddr == ADDR_W'({DATA_IDX, 2'b00});

  // Two steps of one transfer
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence

  AST_PREADY_WAIT: assert property (s_setup ##1 s_access |=> pready)
    else $error("pready not one cycle after access");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_PREADY_CAUSE: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  AST_SLVERR_MAP: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match address map");
  AST_RD_UPPER: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  AST_ERR_RDZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_OPEN_DRAIN: assert property (!link_out.clk_o && !link_out.dat_o)
    else $error("line driven high");
  AST_DAT_AT_REL: assert property ($changed(link_out.dat_oe) |-> !link_out.clk_oe)
    else $error("data changed while clock pulled low");
  AST_CLK_LOW_MIN: assert property ($rose(link_out.clk_oe) |-> link_out.clk_oe[*8])
    else $error("clock low phase too short");
  AST_RST_QUIET: assert property ($rose(presetn) |-> !irq && !link_out.clk_oe && !link_out.dat_oe)
    else $error("outputs active after reset");
endmodule

bind kmsp_port kmsp_port_checker #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .link_in(link_in), .link_out(link_out), .irq(irq));

// file: bench/kmsp_host_model.sv
`timescale 1ns/100ps
module kmsp_host_model (
  // Clock and wire levels
  input  wire logic       pclk,
  input  wire logic       wclk,
  input  wire logic       wdat,
  // Bench commands
  input  wire logic       clr,
  input  wire logic       req,
  input  wire logic       inhibit,
  input  wire logic       bad_par,
  input  wire logic [7:0] tx_byte,
  // Host drives and observations
  output logic            host_clk_oe,
  output logic            host_dat_oe,
  output logic [10:0]     got,
  output int              n_fall,
  output int              per,
  output logic            ack_seen
);
  logic       clk_q;
  int         cnt = 0;
  logic [9:0] bits;

  // Host may only pull the clock low
  assign host_clk_oe = inhibit;
  // LSB first, odd parity unless told to corrupt it, stop high
  assign bits = {1'b1, ~^tx_byte ^ bad_par, tx_byte};
  // Start bit held as request, next bit after each falling edge
  assign host_dat_oe = req && (n_fall == 0 || (n_fall <= 10 && !bits[n_fall-1]));

  // Sample data on falling clock; time the bit period
  always @(posedge pclk)
  begin
    clk_q <= wclk;
    cnt   <= cnt + 1;
    if (clr)
    begin
      n_fall   <= 0;
      got      <= '0;
      ack_seen <= 1'b0;
    end
    else if (clk_q && !wclk)
    begin
      n_fall <= n_fall + 1;
      got    <= {wdat, got[10:1]};
      per    <= cnt;
      cnt    <= 1;
    end
    if (req && n_fall >= 11 && !wdat && !host_dat_oe)
      ack_seen <= 1'b1;
  end
endmodule

// file: bench/tb_keyboard_mouse_serial_port.sv
`timescale 1ns/100ps
module tb_keyboard_mouse_serial_port;
  import kmsp_pkg::*;
  localparam logic [11:0] A_CTL = 12'({CTRL_IDX, 2'b00});
  localparam logic [11:0] A_CSR = 12'({CSR_IDX, 2'b00});
  localparam logic [11:0] A_DAT = 12'({DATA_IDX, 2'b00});
  logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, last_err;
  logic           clr, req, inh, bad, h_clk_oe, h_dat_oe, ack_seen;
  logic [11:0]    paddr;
  logic [31:0]    pwdata, prdata, d;
  logic [7:0]     tx;
  logic [10:0]    got;
  int             n_fall, per;
  int             n_errors = 0;
  int             cmp_count = 0;
  kmsp_link_in_t  lin;
  kmsp_link_out_t lout;

  // Open-drain wires with pull-ups
  assign lin = {!(lout.clk_oe || h_clk_oe), !(lout.dat_oe || h_dat_oe)};

  kmsp_port #(.ADDR_W(12)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_in(lin), .link_out(lout), .irq(irq));
  kmsp_host_model host_u (.pclk(pclk), .wclk(lin.clk), .wdat(lin.dat), .clr(clr), .req(req),
    .inhibit(inh), .bad_par(bad), .tx_byte(tx), .host_clk_oe(h_clk_oe), .host_dat_oe(h_dat_oe),
    .got(got), .n_fall(n_fall), .per(per), .ack_seen(ack_seen));

  // 100 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic finish_test();
    if (n_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] val);
    cmp_count++;
    if (val !== exp)
    begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, exp, val);
    end
  endtask

  // One APB transfer, held until pready is sampled
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 50)
    begin
      n_errors++;
      $display("[ERR] pready exp 1 got 0");
      finish_test();
    end
  endtask

  // Bounded wait on register bits
  task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
    for (int k = 0; k < 3000; k++)
    begin
      apb(1'b0, a, '0, d);
      if ((d & m) === v)
        return;
    end
    n_errors++;
    $display("[ERR] poll %h exp %h got %h", a, v, d & m);
    finish_test();
  endtask

  task automatic wait_fall(input int n);
    for (int k = 0; k < 2000 && n_fall < n; k++)
      @(posedge pclk);
    chk("falls", 32'(n), 32'(n_fall));
  endtask

  task automatic host_clr();
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
  endtask

  // Reset values, map, config lock, no receive without request
  task automatic sc_regs();
    apb(1'b0, A_CTL, '0, d); chk("ctrl_rst", 32'h0000_0000, d);
    apb(1'b0, A_CSR, '0, d); chk("csr_rst", 32'h0000_0000, d);
    apb(1'b0, A_DAT, '0, d); chk("data_rst", 32'h0000_0000, d);
    apb(1'b0, 12'h144, '0, d); chk("slverr", 32'h0000_0001, 32'(last_err));
    apb(1'b1, A_CSR, 32'h0000_0060, d);
    apb(1'b1, A_CTL, 32'h0000_0001, d);
    apb(1'b1, A_CSR, 32'h0000_0010, d);
    apb(1'b0, A_CSR, '0, d); chk("csr_lock", 32'h0000_0060, d);
    apb(1'b1, A_CTL, 32'h0000_0007, d);
    apb(1'b0, A_CTL, '0, d); chk("rx_refused", 32'h0000_0003, d);
    apb(1'b1, A_CTL, 32'h0000_0079, d);
  endtask

  // Full frame out, flags, period, clear by one
  task automatic sc_tx();
    host_clr();
    apb(1'b1, A_DAT, 32'h0000_00A5, d);
    poll(A_CTL, 32'h0000_0004, 32'h0000_0004);
    poll(A_CSR, 32'h0000_0001, 32'h0000_0001);
    apb(1'b0, A_CTL, '0, d); chk("tx_done", 32'h0000_0079, d);
    chk("frame", 32'({1'b1, ~^8'hA5, 8'hA5, 1'b0}), 32'(got));
    chk("period", 32'(2 * int'(HALF_TK) * 10), 32'(per));
    chk("irq_cmp", 32'h0000_0001, 32'(irq));
    apb(1'b1, A_CSR, 32'h0000_006F, d);
    apb(1'b0, A_CSR, '0, d); chk("w1c", 32'h0000_0060, d);
    chk("irq_clr", 32'h0000_0000, 32'(irq));
  endtask

  // Abort by software or by host inhibit, as chosen by by_host
  task automatic sc_abort(input logic by_host);
    host_clr();
    apb(1'b1, A_DAT, 32'h0000_00F0, d);
    poll(A_CTL, 32'h0000_0004, 32'h0000_0004);
    wait_fall(2);
    // Abort in the released phase so no clock low pulse is cut short
    repeat (200) @(posedge pclk);
    if (by_host)
      inh <= 1'b1;
    else
      apb(1'b1, A_CTL, 32'h0000_0079, d);
    poll(A_CSR, 32'h0000_0002, 32'h0000_0002);
    apb(1'b0, A_CSR, '0, d); chk("abort", 32'h0000_0062, d);
    chk("irq_abt", 32'h0000_0001, 32'(irq));
    inh <= 1'b0;
    apb(1'b1, A_CSR, 32'h0000_006F, d);
  endtask

  // Host request: mid-frame abort or from idle, then reception
  task automatic sc_rx(input logic mid, input logic [7:0] b, input logic p);
    if (mid)
    begin
      host_clr();
      apb(1'b1, A_DAT, 32'h0000_00FF, d);
      wait_fall(2);
    end
    clr <= 1'b1;
    req <= 1'b1;
    tx <= b;
    bad <= p;
    @(posedge pclk);
    clr <= 1'b0;
    poll(A_CSR, 32'h0000_0006, {29'h0, 2'b11 & {1'b1, mid}, 1'b0});
    apb(1'b1, A_CSR, 32'h0000_006F, d);
    repeat (500) @(posedge pclk);
    apb(1'b1, A_CTL, 32'h0000_007B, d);
    apb(1'b1, A_CTL, 32'h0000_007F, d);
    apb(1'b0, A_CTL, '0, d); chk("rx_start", 32'h0000_007F, d);
    poll(A_CSR, 32'h0000_0001, 32'h0000_0001);
    apb(1'b0, A_CSR, '0, d); chk("rx_csr", {28'h000_0006, p, 3'b001}, d);
    apb(1'b0, A_DAT, '0, d); chk("rx_data", p ? 32'h0000_0000 : 32'(b), d);
    chk("ack", 32'h0000_0001, 32'(ack_seen));
    chk("irq_rx", 32'h0000_0001, 32'(irq));
    req <= 1'b0;
    apb(1'b1, A_CSR, 32'h0000_006F, d);
    apb(1'b1, A_CTL, 32'h0000_0079, d);
  endtask

  // Main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    clr = 1'b1;
    req = 1'b0;
    inh = 1'b0;
    bad = 1'b0;
    tx = 8'h00;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    sc_regs();
    sc_tx();
    sc_abort(1'b0);
    sc_abort(1'b1);
    sc_rx(1'b1, 8'h5A, 1'b0);
    sc_rx(1'b0, 8'h81, 1'b1);
    finish_test();
  end
endmodule
